// *** rtl/ssr_pkg.sv ***
// Constants, types and helpers shared by the setpoint select and ramp block
package ssr_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PV_W     = 16;
   localparam int RATE_W   = 14;
   localparam int FRAC_W   = 20;
   localparam int GRP_W    = 4;
   localparam int FUNC_W   = 5;
   localparam int N_DI     = 5;
   localparam int TBL_AW   = 4;
   localparam int TBL_SIZE = 9;

   // ----------------------------------------------------------------
   // Group numbers and reset values
   // ----------------------------------------------------------------
   localparam logic [GRP_W-1:0]  GRP_MIN        = 4'h1;
   localparam logic [GRP_W-1:0]  GRP_MAX        = 4'h8;
   localparam logic [GRP_W-1:0]  GRP_RESET      = 4'h1;
   localparam logic [TBL_AW-1:0] TBL_REMOTE_IDX = 4'h0;
   localparam int                DISP_GRP_BIT   = 2;
   localparam logic [RATE_W-1:0] RATE_MAX       = 14'h270f;

   // ----------------------------------------------------------------
   // Contact function codes
   // ----------------------------------------------------------------
   localparam logic [FUNC_W-1:0] DI_FUNC_NONE = 5'h00;
   localparam logic [FUNC_W-1:0] DI_FUNC_W1   = 5'h01;
   localparam logic [FUNC_W-1:0] DI_FUNC_W2   = 5'h02;
   localparam logic [FUNC_W-1:0] DI_FUNC_W4   = 5'h03;

   // ----------------------------------------------------------------
   // Ramp type and time unit
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SSR_RT_STD, SSR_RT_MULTI, SSR_RT_STEP_STOP, SSR_RT_STEP_RESUME} ssr_ramp_type_t;
   localparam logic [1:0] RAMP_TYPE_RESET = 2'h0;
   localparam logic [1:0] UNIT_PER_SEC    = 2'h0;
   localparam logic [1:0] UNIT_PER_MIN    = 2'h1;
   localparam logic [1:0] UNIT_PER_HOUR   = 2'h2;
   localparam logic [1:0] UNIT_RESET      = 2'h1;

   // ----------------------------------------------------------------
   // Timing: rate is in tenths of a process value step per time unit
   // ----------------------------------------------------------------
   localparam int TICK_PERIOD_MS = 100;
   localparam int SEC_PER_MIN    = 60;
   localparam int SEC_PER_HOUR   = 3600;
   localparam int RATE_FINE_DIV  = 10;
   localparam int DIV_SEC  = RATE_FINE_DIV * 1000 / TICK_PERIOD_MS;
   localparam int DIV_MIN  = DIV_SEC * SEC_PER_MIN;
   localparam int DIV_HOUR = DIV_SEC * SEC_PER_HOUR;

   typedef enum logic {SSR_HOLD, SSR_RAMP} ssr_state_t;

   // Fraction needed per whole process value step
   function automatic logic [FRAC_W-1:0] ssr_unit_div(input logic [1:0] unit);
      if (unit == UNIT_PER_SEC) begin
         return FRAC_W'(DIV_SEC);
      end else if (unit == UNIT_PER_HOUR) begin
         return FRAC_W'(DIV_HOUR);
      end else begin
         return FRAC_W'(DIV_MIN);
      end
   endfunction

   // Rate clipped to its legal range
   function automatic logic [RATE_W-1:0] ssr_rate_clip(input logic [RATE_W-1:0] r);
      return (r > RATE_MAX) ? RATE_MAX : r;
   endfunction

   // Group count forced into 1..8
   function automatic logic [GRP_W-1:0] ssr_count_clip(input logic [GRP_W-1:0] c);
      if (c < GRP_MIN) begin
         return GRP_MIN;
      end else if (c > GRP_MAX) begin
         return GRP_MAX;
      end else begin
         return c;
      end
   endfunction

   // Selection weight of one contact
   function automatic logic [GRP_W-1:0] ssr_di_weight(input logic [FUNC_W-1:0] f, input logic on);
      if (!on) begin
         return 4'h0;
      end else if (f == DI_FUNC_W1) begin
         return 4'h1;
      end else if (f == DI_FUNC_W2) begin
         return 4'h2;
      end else if (f == DI_FUNC_W4) begin
         return 4'h4;
      end else begin
         return 4'h0;
      end
   endfunction

endpackage

// *** rtl/ssr_group_table.sv ***
// Table of control parameter group numbers, remote entry plus eight local
`timescale 1ns/10ps
`default_nettype none
module ssr_group_table
   import ssr_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              wr_i,
   input  wire logic [TBL_AW-1:0] wr_addr_i,
   input  wire logic [GRP_W-1:0]  wr_data_i,
   input  wire logic [TBL_AW-1:0] rd_addr_i,
   output var  logic [GRP_W-1:0]  rd_data_o
);

   logic [GRP_W-1:0] mem_reg [TBL_SIZE];
   logic             wr_ok;

   assign wr_ok = wr_i && (wr_addr_i < TBL_AW'(TBL_SIZE))
                  && (wr_data_i >= GRP_MIN) && (wr_data_i <= GRP_MAX);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < TBL_SIZE; i++) begin
            mem_reg[i] <= GRP_RESET;
         end
      end else if (wr_ok) begin
         mem_reg[wr_addr_i] <= wr_data_i; // [RULE1]
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_o <= GRP_RESET;
      end else if (rd_addr_i < TBL_AW'(TBL_SIZE)) begin
         rd_data_o <= mem_reg[rd_addr_i];
      end
   end

endmodule
`default_nettype wire

// *** rtl/ssr_setpoint_select_ramp.sv ***
// Local group selection, parameter group lookup and setpoint rate limiter
// Function
// RULE1: Nine parameter group numbers, 1 to 8, default 1
// RULE2: Manual group set only if displayable, no contacts
// RULE3: Displayable when count at least 2, bit 2
// RULE4: Contact codes 0 none, 1/2/3 weights 1/2/4
// RULE5: Contact adds weight when on, zero when off
// RULE6: Group equals contact sum plus one
// RULE7: Contact group saturates at configured count
// RULE8: Count of one ignores contact selection
// RULE9: Unit code 0 second, 1 minute, 2 hour
// RULE10: Separate rise/fall rates, zero disables that direction
// RULE11: Rates apply only for standard ramp type
// RULE12: Zero-rate direction changes apply at once
// RULE13: Restart ramp from process value on events
// RULE14: Restart only if direction rate is nonzero
// RULE15: Remote setpoint is never rate limited
// RULE16: Rate is one decimal finer than process value
// RULE17: Ramp type codes 0 to 3, default 0
// RULE18: Local group count 1 to 8, default 1
// RULE19: Step toward target per tick, stop exactly
// RULE20: Output parameter group of active source
`timescale 1ns/10ps
`default_nettype none
module ssr_setpoint_select_ramp
   import ssr_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   input  wire logic                    sample_tick_i,
   input  wire logic [GRP_W-1:0]        local_group_count_i,
   input  wire logic [7:0]              display_config_i,
   input  wire logic [1:0]              ramp_type_i,
   input  wire logic [1:0]              ramp_time_unit_i,
   input  wire logic [RATE_W-1:0]       rise_rate_i,
   input  wire logic [RATE_W-1:0]       fall_rate_i,
   input  wire logic [N_DI-1:0]         contact_i,
   input  wire logic [FUNC_W-1:0]       contact1_func_i,
   input  wire logic [FUNC_W-1:0]       contact2_func_i,
   input  wire logic [FUNC_W-1:0]       contact3_func_i,
   input  wire logic [FUNC_W-1:0]       contact4_func_i,
   input  wire logic [FUNC_W-1:0]       contact5_func_i,
   input  wire logic                    group_set_i,
   input  wire logic [GRP_W-1:0]        group_set_value_i,
   input  wire logic                    param_group_wr_i,
   input  wire logic [TBL_AW-1:0]       param_group_addr_i,
   input  wire logic [GRP_W-1:0]        param_group_value_i,
   input  wire logic                    remote_mode_i,
   input  wire logic signed [PV_W-1:0]  remote_setpoint_i,
   input  wire logic signed [PV_W-1:0]  local_setpoint_i,
   input  wire logic signed [PV_W-1:0]  process_value_i,
   input  wire logic                    run_i,
   input  wire logic                    auto_i,
   input  wire logic                    autotune_i,
   output var  logic [GRP_W-1:0]        active_group_o,
   output logic                         group_displayable_o,
   output logic                         group_settable_o,
   output var  logic [GRP_W-1:0]        control_param_group_o,
   output var  logic signed [PV_W-1:0]  setpoint_o,
   output logic                         ramping_o
);

   // ----------------------------------------------------------------
   // Group selection
   // ----------------------------------------------------------------
   logic [FUNC_W-1:0] func_w [N_DI];
   logic [GRP_W-1:0]  count_w;
   logic [GRP_W+1:0]  di_sum_w;
   logic [GRP_W+1:0]  di_grp_w;
   logic              di_assigned_w;
   logic [GRP_W-1:0]  sel_w;
   logic [GRP_W-1:0]  manual_group_reg;

   assign func_w[0] = contact1_func_i;
   assign func_w[1] = contact2_func_i;
   assign func_w[2] = contact3_func_i;
   assign func_w[3] = contact4_func_i;
   assign func_w[4] = contact5_func_i;
   assign count_w   = ssr_count_clip(local_group_count_i); // [RULE18]

   always_comb begin
      di_sum_w      = '0;
      di_assigned_w = 1'b0;
      for (int i = 0; i < N_DI; i++) begin
         di_sum_w = di_sum_w + (GRP_W+2)'(ssr_di_weight(func_w[i], contact_i[i])); // [RULE4] [RULE5]
         if (func_w[i] == DI_FUNC_W1 || func_w[i] == DI_FUNC_W2 || func_w[i] == DI_FUNC_W4) begin
            di_assigned_w = 1'b1; // [RULE4]
         end
      end
   end

   assign di_grp_w = di_sum_w + (GRP_W+2)'(GRP_MIN); // [RULE6]

   assign group_displayable_o = (count_w >= 4'h2) && display_config_i[DISP_GRP_BIT]; // [RULE3]
   assign group_settable_o    = group_displayable_o && !di_assigned_w; // [RULE2]

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         manual_group_reg <= GRP_RESET;
      end else if (group_set_i && group_settable_o && group_set_value_i >= GRP_MIN
                   && group_set_value_i <= count_w) begin
         manual_group_reg <= group_set_value_i; // [RULE2]
      end
   end

   always_comb begin
      if (di_assigned_w && count_w != GRP_MIN) begin
         if (di_grp_w > (GRP_W+2)'(count_w)) begin
            sel_w = count_w; // [RULE7]
         end else begin
            sel_w = di_grp_w[GRP_W-1:0]; // [RULE6]
         end
      end else if (count_w == GRP_MIN) begin
         sel_w = GRP_MIN; // [RULE8]
      end else if (manual_group_reg > count_w) begin
         sel_w = count_w;
      end else begin
         sel_w = manual_group_reg;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_group_o <= GRP_RESET;
      end else begin
         active_group_o <= sel_w;
      end
   end

   // ----------------------------------------------------------------
   // Parameter group of the active source
   // ----------------------------------------------------------------
   logic [TBL_AW-1:0] tbl_rd_addr_w;

   assign tbl_rd_addr_w = remote_mode_i ? TBL_REMOTE_IDX : TBL_AW'(active_group_o); // [RULE20]

   ssr_group_table u_table (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .wr_i      (param_group_wr_i),
      .wr_addr_i (param_group_addr_i),
      .wr_data_i (param_group_value_i),
      .rd_addr_i (tbl_rd_addr_w),
      .rd_data_o (control_param_group_o)
   );

   // ----------------------------------------------------------------
   // Restart events
   // ----------------------------------------------------------------
   logic power_up_reg;
   logic run_reg;
   logic auto_reg;
   logic at_reg;
   logic restart_w;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         power_up_reg <= 1'b1;
         run_reg      <= 1'b0;
         auto_reg     <= 1'b0;
         at_reg       <= 1'b0;
      end else begin
         power_up_reg <= 1'b0;
         run_reg      <= run_i;
         auto_reg     <= auto_i;
         at_reg       <= autotune_i;
      end
   end

   assign restart_w = power_up_reg // [RULE13]
                      || (!run_reg && run_i && auto_i)
                      || (run_i && !auto_reg && auto_i)
                      || (at_reg && !autotune_i);

   // ----------------------------------------------------------------
   // Ramp
   // ----------------------------------------------------------------
   ssr_state_t               state_reg;
   logic signed [PV_W-1:0]   target_w;
   logic [RATE_W-1:0]        rise_w;
   logic [RATE_W-1:0]        fall_w;
   logic [RATE_W-1:0]        rate_w;
   logic [RATE_W-1:0]        pv_rate_w;
   logic [FRAC_W-1:0]        div_w;
   logic                     bypass_w;
   logic                     up_w;
   logic                     step_w;
   logic [FRAC_W-1:0]        frac_reg;
   logic [FRAC_W-1:0]        frac_next;
   logic signed [PV_W-1:0]   sp_next;
   ssr_state_t               state_next;

   assign target_w  = remote_mode_i ? remote_setpoint_i : local_setpoint_i;
   assign rise_w    = ssr_rate_clip(rise_rate_i); // [RULE10]
   assign fall_w    = ssr_rate_clip(fall_rate_i); // [RULE10]
   assign bypass_w  = remote_mode_i || (ramp_type_i != 2'(SSR_RT_STD)); // [RULE15] [RULE11] [RULE17]
   assign up_w      = target_w > setpoint_o;
   assign rate_w    = up_w ? rise_w : fall_w; // [RULE12]
   assign pv_rate_w = (target_w > process_value_i) ? rise_w : fall_w; // [RULE14]
   assign div_w     = ssr_unit_div(ramp_time_unit_i); // [RULE9] [RULE16]
   assign step_w    = frac_reg >= div_w; // [RULE19]

   always_comb begin
      sp_next    = setpoint_o;
      frac_next  = frac_reg;
      state_next = state_reg;
      if (bypass_w) begin
         sp_next    = target_w; // [RULE15] [RULE11]
         frac_next  = '0;
         state_next = SSR_HOLD;
      end else if (restart_w) begin
         frac_next = '0;
         if (pv_rate_w != '0 && process_value_i != target_w) begin
            sp_next    = process_value_i; // [RULE13] [RULE14]
            state_next = SSR_RAMP;
         end else begin
            sp_next    = target_w; // [RULE14]
            state_next = SSR_HOLD;
         end
      end else if (setpoint_o == target_w) begin
         frac_next  = '0;
         state_next = SSR_HOLD;
      end else if (rate_w == '0) begin
         sp_next    = target_w; // [RULE12] [RULE10]
         frac_next  = '0;
         state_next = SSR_HOLD;
      end else begin
         state_next = SSR_RAMP;
         frac_next  = frac_reg + (sample_tick_i ? FRAC_W'(rate_w) : '0) - (step_w ? div_w : '0);
         if (step_w) begin
            sp_next = up_w ? setpoint_o + 16'sh0001 : setpoint_o - 16'sh0001; // [RULE19]
            if (sp_next == target_w) begin
               frac_next  = '0;
               state_next = SSR_HOLD;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         setpoint_o <= '0;
      end else begin
         setpoint_o <= sp_next;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frac_reg <= '0;
      end else begin
         frac_reg <= frac_next;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= SSR_HOLD;
      end else begin
         case (state_next)
            SSR_RAMP: state_reg <= SSR_RAMP;
            default:  state_reg <= SSR_HOLD;
         endcase
      end
   end

   assign ramping_o = (state_reg == SSR_RAMP);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_PARAM_GROUP_RANGE: assert property ( // [RULE1]
      control_param_group_o >= GRP_MIN && control_param_group_o <= GRP_MAX)
      else $error("parameter group out of 1..8");

   AST_MANUAL_REFUSED: assert property ( // [RULE2]
      (group_set_i && !group_settable_o) |=> manual_group_reg == $past(manual_group_reg))
      else $error("manual group taken while not settable");

   AST_DISPLAY_COND: assert property ( // [RULE3]
      group_displayable_o |-> (local_group_count_i >= 4'h2 && display_config_i[DISP_GRP_BIT]))
      else $error("group shown with count below two or bit clear");

   AST_CONTACT_ONE: assert property ( // [RULE6]
      (contact1_func_i == DI_FUNC_W1 && contact_i == 5'h01 && contact2_func_i == DI_FUNC_NONE
       && contact3_func_i == DI_FUNC_NONE && contact4_func_i == DI_FUNC_NONE
       && contact5_func_i == DI_FUNC_NONE && count_w >= 4'h2)
      |=> active_group_o == 4'h2)
      else $error("single weight-one contact did not give group two");

   AST_GROUP_SATURATE: assert property ( // [RULE7]
      active_group_o >= GRP_MIN && active_group_o <= ssr_count_clip($past(local_group_count_i)))
      else $error("active group beyond configured count");

   AST_COUNT_ONE: assert property ( // [RULE8]
      (count_w == GRP_MIN) |=> active_group_o == GRP_MIN)
      else $error("contacts changed group with count one");

   AST_REMOTE_DIRECT: assert property ( // [RULE15]
      remote_mode_i |=> setpoint_o == $past(remote_setpoint_i) && !ramping_o)
      else $error("remote setpoint was rate limited");

   AST_NONSTD_DIRECT: assert property ( // [RULE11]
      (!remote_mode_i && ramp_type_i != 2'h0) |=> setpoint_o == $past(local_setpoint_i))
      else $error("nonstandard ramp type still ramped");

   AST_ZERO_RISE: assert property ( // [RULE12]
      (!bypass_w && !restart_w && rise_w == '0 && target_w > setpoint_o) |=> setpoint_o == $past(target_w))
      else $error("rise with zero rate not applied at once");

   AST_RESTART_PV: assert property ( // [RULE14]
      (!bypass_w && restart_w && pv_rate_w != '0 && process_value_i != target_w)
      |=> setpoint_o == $past(process_value_i) ##1 ramping_o || setpoint_o == $past(local_setpoint_i))
      else $error("restart did not begin from process value");

   AST_RESTART_DIRECT: assert property ( // [RULE14]
      (!bypass_w && restart_w && pv_rate_w == '0) |=> setpoint_o == $past(target_w) && !ramping_o)
      else $error("restart with zero rate did not apply target");

   AST_HOLD_STILL: assert property ( // [RULE19]
      (!bypass_w && !restart_w && setpoint_o == target_w) |=> setpoint_o == $past(setpoint_o))
      else $error("setpoint moved while at target");

   AST_STEP_ONE: assert property ( // [RULE19]
      (ramping_o && !bypass_w && !restart_w && $stable(target_w) && rate_w != '0)
      |=> (setpoint_o - $past(setpoint_o) <= 16'sh0001) && ($past(setpoint_o) - setpoint_o <= 16'sh0001))
      else $error("ramp moved more than one step per cycle");

   AST_NO_OVERSHOOT: assert property ( // [RULE19]
      (ramping_o && !bypass_w && !restart_w && up_w && $stable(target_w)) |=> setpoint_o <= $past(target_w))
      else $error("rising ramp passed its target");

   AST_NO_UNDERSHOOT: assert property ( // [RULE19]
      (ramping_o && !bypass_w && !restart_w && !up_w && $stable(target_w)) |=> setpoint_o >= $past(target_w))
      else $error("falling ramp passed its target");

   COV_RAMP_DONE: cover property (ramping_o ##1 !ramping_o && setpoint_o == target_w);
   COV_RESTART:   cover property (restart_w && pv_rate_w != '0 && !bypass_w);
   COV_SATURATE:  cover property (di_assigned_w && di_grp_w > (GRP_W+2)'(count_w) && count_w > GRP_MIN);
   COV_REMOTE:    cover property (remote_mode_i ##1 !remote_mode_i);

endmodule
`default_nettype wire

// *** dv/ssr_loop_model.sv ***
// Behavioural model of the local setpoint table and process value source
`timescale 1ns/10ps
`default_nettype none
module ssr_loop_model
   import ssr_pkg::*;
(
   input  wire logic [GRP_W-1:0]        active_group_i,
   input  wire logic signed [PV_W-1:0]  base_i,
   input  wire logic signed [PV_W-1:0]  pv_i,
   output logic signed [PV_W-1:0]       local_setpoint_o,
   output logic signed [PV_W-1:0]       process_value_o
);
   // Each local group holds base plus ten per group number
   assign local_setpoint_o = base_i + {12'h000, active_group_i} * 16'h000a;
   assign process_value_o  = pv_i;
endmodule
`default_nettype wire

// *** dv/test_setpoint_select_ramp.sv ***
// Self-checking bench for the setpoint select and ramp block
`timescale 1ns/10ps
`default_nettype none
module test_setpoint_select_ramp;
   import ssr_pkg::*;
   logic                   clk = 1'b0, arst_n = 1'b0, tick = 1'b0, gset = 1'b0, pwr = 1'b0;
   logic                   rmode = 1'b0, run = 1'b0, auto = 1'b1, at = 1'b0;
   logic [GRP_W-1:0]       cnt = 4'h1, gval = 4'h1, pval = 4'h1, agrp, cpg;
   logic [TBL_AW-1:0]      paddr = 4'h0;
   logic [7:0]             dcfg = 8'h00;
   logic [1:0]             rtype = 2'h0, unit = 2'h1;
   logic [RATE_W-1:0]      rise = 14'h0000, fall = 14'h0000;
   logic [N_DI-1:0]        contact = 5'h00;
   logic [FUNC_W-1:0]      f1 = 5'h00, f2 = 5'h00, f3 = 5'h00, f4 = 5'h00, f5 = 5'h00;
   logic signed [PV_W-1:0] rsp = 16'h0000, base = 16'h0000, pv = 16'h0000, local_setpoint, pvm, sp;
   logic                   disp, sett, ramping;
   int                     fail_count = 0, check_count = 0, cycles = 0;

   always #50 clk = ~clk;

   ssr_setpoint_select_ramp i_ssr_setpoint_select_ramp (
      .clk_i(clk), .arst_n_i(arst_n), .sample_tick_i(tick), .local_group_count_i(cnt),
      .display_config_i(dcfg), .ramp_type_i(rtype), .ramp_time_unit_i(unit), .rise_rate_i(rise),
      .fall_rate_i(fall), .contact_i(contact), .contact1_func_i(f1), .contact2_func_i(f2),
      .contact3_func_i(f3), .contact4_func_i(f4), .contact5_func_i(f5), .group_set_i(gset),
      .group_set_value_i(gval), .param_group_wr_i(pwr), .param_group_addr_i(paddr),
      .param_group_value_i(pval), .remote_mode_i(rmode), .remote_setpoint_i(rsp),
      .local_setpoint_i(local_setpoint), .process_value_i(pvm), .run_i(run), .auto_i(auto), .autotune_i(at),
      .active_group_o(agrp), .group_displayable_o(disp), .group_settable_o(sett),
      .control_param_group_o(cpg), .setpoint_o(sp), .ramping_o(ramping));

   ssr_loop_model i_ssr_loop_model (
      .active_group_i(agrp), .base_i(base), .pv_i(pv), .local_setpoint_o(local_setpoint), .process_value_o(pvm));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string n, input logic [PV_W-1:0] e, input logic [PV_W-1:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
         cyc(3);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_contacts;
      cnt = 4'h8;
      dcfg = 8'h04;
      f1 = DI_FUNC_W1;
      f2 = DI_FUNC_W2;
      f3 = DI_FUNC_W4;
      contact = 5'h07;
      cyc(3);
      chk("group", 16'h0008, agrp);
      chk("shown", 16'h0001, disp);
      chk("settable", 16'h0000, sett);
      contact = 5'h05;
      cyc(3);
      chk("group", 16'h0006, agrp);
      cnt = 4'h3;
      cyc(3);
      chk("group", 16'h0003, agrp);
      f2 = DI_FUNC_NONE;
      f3 = DI_FUNC_NONE;
      contact = 5'h01;
      cyc(3);
      chk("group", 16'h0002, agrp);
      cnt = 4'h1;
      cyc(3);
      chk("group", 16'h0001, agrp);
      chk("shown", 16'h0000, disp);
   endtask

   task automatic t_manual;
      f1 = DI_FUNC_NONE;
      f2 = DI_FUNC_NONE;
      f3 = DI_FUNC_NONE;
      cnt = 4'h8;
      cyc(2);
      chk("settable", 16'h0001, sett);
      gval = 4'h5;
      gset = 1'b1;
      cyc(1);
      gval = 4'h9;
      cyc(1);
      gset = 1'b0;
      cyc(2);
      chk("group", 16'h0005, agrp);
      dcfg = 8'h00;
      cyc(1);
      chk("settable", 16'h0000, sett);
      gval = 4'h3;
      gset = 1'b1;
      cyc(1);
      gset = 1'b0;
      cyc(2);
      chk("group", 16'h0005, agrp);
   endtask

   task automatic t_ramp;
      base = 16'hffd8;
      cyc(3);
      chk("setpoint", 16'h000a, sp);
      unit = UNIT_PER_SEC;
      rise = 14'h00c8;
      base = 16'hffec;
      cyc(3);
      chk("setpoint", 16'h000a, sp);
      ticks(5);
      chk("setpoint", 16'h0014, sp);
      chk("ramping", 16'h0001, ramping);
      ticks(7);
      chk("setpoint", 16'h001e, sp);
      chk("ramping", 16'h0000, ramping);
      base = 16'hffd8;
      cyc(3);
      chk("setpoint", 16'h000a, sp);
      unit = UNIT_PER_MIN;
      base = 16'hffec;
      ticks(5);
      chk("setpoint", 16'h000a, sp);
      rtype = 2'h1;
      cyc(3);
      chk("setpoint", 16'h001e, sp);
      rtype = 2'h0;
      base = 16'hffd8;
      cyc(3);
      chk("setpoint", 16'h000a, sp);
      unit = UNIT_PER_SEC;
      fall = 14'h00c8;
      base = 16'hffce;
      ticks(3);
      chk("setpoint", 16'h0004, sp);
      unit = UNIT_PER_HOUR;
      rise = 14'h3fff;
      base = 16'hffec;
      ticks(36);
      chk("setpoint", 16'h0004, sp);
      ticks(1);
      chk("setpoint", 16'h0005, sp);
      unit = UNIT_PER_MIN;
      rise = 14'h00c8;
      fall = 14'h0000;
      base = 16'hffd8;
   endtask

   task automatic t_restart;
      pv = 16'hffce;
      run = 1'b1;
      cyc(2);
      chk("setpoint", 16'hffce, sp);
      run = 1'b0;
      pv = 16'h0064;
      cyc(1);
      run = 1'b1;
      cyc(2);
      chk("setpoint", 16'h000a, sp);
      pv = 16'hffce;
      at = 1'b1;
      cyc(2);
      at = 1'b0;
      cyc(2);
      chk("setpoint", 16'hffce, sp);
      auto = 1'b0;
      cyc(2);
      pv = 16'hffe2;
      auto = 1'b1;
      cyc(2);
      chk("setpoint", 16'hffe2, sp);
   endtask

   task automatic t_table;
      chk("param group", 16'h0001, cpg);
      pwr = 1'b1;
      paddr = 4'h5;
      pval = 4'h7;
      cyc(1);
      paddr = TBL_REMOTE_IDX;
      pval = 4'h4;
      cyc(1);
      pwr = 1'b0;
      cyc(3);
      chk("param group", 16'h0007, cpg);
      rmode = 1'b1;
      rsp = 16'h0064;
      cyc(3);
      chk("param group", 16'h0004, cpg);
      chk("setpoint", 16'h0064, sp);
      rmode = 1'b0;
      cyc(3);
      chk("param group", 16'h0007, cpg);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      cyc(4);
      arst_n = 1'b1;
      cyc(2);
      chk("group", 16'h0001, agrp);
      chk("setpoint", 16'h000a, sp);
      t_contacts();
      t_manual();
      t_ramp();
      t_restart();
      t_table();
      complete_run();
   end
endmodule
`default_nettype wire
